/* File: hw/sbc_secondary.sv */
// Purpose: secondary-side sequencer: hand-over, half-cycle timing, burst modes, fault reporting
// Assumes: sense inputs are pin codes from converters, sampled through two flops
// Notes:   compensation node is a digital integrator standing in for the analog network
`timescale 1ns/1ns
`default_nettype none
module sbc_secondary
  import sbc_pkg::*;
#(
  parameter int IM_PERIOD   = IM_PERIOD_CYC,  // off-to-off period in cycles
  parameter int SL_OFF      = SL_OFF_CYC,     // super-light off time in cycles
  parameter int ENV_MIN     = ENV_MIN_CYC,    // least spacing of light-load bursts
  parameter int SL_STEP_HC  = 4,              // short burst length that steps to super-light
  parameter int LL_EXIT_HC  = 64              // long burst length that steps back up
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  sbc_link_if.sec          link,
  input  wire logic [11:0] outputFeedbackSense,
  input  wire logic [11:0] windingCurrentSense,
  input  wire logic [7:0]  lineSense,
  input  wire logic [2:0]  secondaryStrapSelect,
  input  wire logic        secFault,
  input  wire logic        secUnderVolt,
  output logic             inControl,
  output logic [1:0]       burstMode,
  output logic [11:0]      compensationNode
);
  if (IM_PERIOD < 2 || IM_PERIOD >= 2**TMR_W || SL_OFF < 2 || SL_OFF >= 2**TMR_W ||
      ENV_MIN < 1 || ENV_MIN >= 2**16 || SL_STEP_HC > 254 || LL_EXIT_HC > 255 ||
      SL_STEP_HC >= LL_EXIT_HC) begin : g_chk
    $error("sbc_secondary: parameter out of range");
  end
  // ***************************************************************
  // state
  // ***************************************************************
  typedef enum logic [8:0] {
    S_WAIT   = 9'h001, S_RUN    = 9'h002, S_IM_ON  = 9'h004,
    S_IM_OFF = 9'h008, S_LL_ON  = 9'h010, S_LL_OFF = 9'h020,
    S_SL_ON  = 9'h040, S_SL_OFF = 9'h080, S_FAULT  = 9'h100
  } sbc_sst_t;
  typedef struct packed {
    sbc_sst_t         st;        // sequencer state
    logic [11:0]      cmp;       // compensation level
    logic             phase;     // next half-cycle side
    logic             above;     // current above level last cycle
    logic [TMR_W-1:0] tmr;       // off-to-off or off-time timer
    logic [15:0]      env;       // time since last burst start
    logic [7:0]       hc;        // half-cycles in this burst
    logic [10:0]      sw;        // super-light switching time
    sbc_cmd_t         cmd;       // command to primary
    logic             stb;       // command strobe
    logic [2:0]       strap;     // captured strap
    logic             strapDone; // strap caught once after reset
    logic             inCtl;     // secondary owns switching
    logic [1:0]       mode;      // burst mode shown outside
  } sbc_sec_t;
  sbc_sec_t q, d;
  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  logic [11:0] fbS;      // feedback code
  logic [11:0] isS;      // winding current code
  logic [7:0]  lineS;    // input voltage code
  logic [2:0]  strapS;   // strap code
  logic [1:0]  fltS;     // fault, undervoltage
  sbc_sync #(.W(37)) u_pins (
    .sys_clk (sys_clk),
    .rst     (rst),
    .asyncIn ({outputFeedbackSense, windingCurrentSense, lineSense, secondaryStrapSelect,
               secFault, secUnderVolt}),
    .syncOut ({fbS, isS, lineS, strapS, fltS})
  );
  // ***************************************************************
  // datapath terms
  // ***************************************************************
  logic signed [12:0] err;       // feedback minus reference
  logic        [12:0] absErr;    // magnitude of error
  logic signed [14:0] gErr;      // error after gain choice
  logic signed [14:0] cmpW;      // integrator before clamp
  logic        [11:0] cmpSat;    // clamped integrator
  logic        [11:0] burstThr;  // compensated entry threshold
  logic        [11:0] level;     // half-cycle termination level
  logic               above;     // current at or above level
  logic               switching; // a switching state
  logic               hcEnd;     // half-cycle termination event
  logic               winLow;    // output at low window
  logic               winHigh;   // output at high window
  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    d = q;
    d.cmd = CMD_NONE;
    d.stb = 1'b0;
    // error amplifier with large-signal boost
    err    = $signed({1'b0, fbS}) - $signed({1'b0, OUT_REG_CODE});
    absErr = err[12] ? 13'(-err) : 13'(err);
    gErr   = (absErr > NLA_THR) ? (15'(err) <<< NLA_SHIFT) : 15'(err);
    cmpW   = $signed({3'b000, q.cmp}) - (gErr >>> INT_SHIFT);
    cmpSat = cmpW[14] ? 12'h000 : (cmpW > 15'sd4095) ? 12'hfff : cmpW[11:0];
    burstThr = STRAP_LVL[q.strap] + {4'h0, lineS >> LINE_SHIFT};
    winLow   = fbS <= WIN_LOW_CODE;
    winHigh  = fbS >= WIN_HIGH_CODE;
    // strap taken once synchronised feedback is above the low window; until the synchroniser fills it still shows its reset zero
    if (!q.strapDone && !winLow) begin
      d.strap     = strapS;
      d.strapDone = 1'b1;
    end
    // light-load and super-light ignore the compensation node
    level = (q.st == S_LL_ON || q.st == S_SL_ON) ? FIXED_BURST_LVL : q.cmp;
    above = isS >= level;
    switching = q.st == S_RUN || q.st == S_IM_ON || q.st == S_LL_ON || q.st == S_SL_ON;
    hcEnd = switching && above && !q.above;
    d.above = above;
    d.tmr = (q.tmr == '1) ? q.tmr : q.tmr + 1'b1;
    d.env = (q.env == '1) ? q.env : q.env + 1'b1;
    // closed loop only while the node is in use
    if (q.st == S_RUN || q.st == S_IM_ON) begin
      d.cmp = cmpSat;
    end
    case (q.st)
      S_WAIT: begin
        if (link.primaryOn && !winLow) begin
          d.st    = S_RUN;                                    // near regulation: take over
          d.cmd   = CMD_HANDOVER;
          d.stb   = 1'b1;
          d.inCtl = 1'b1;
          d.cmp   = CMP_INIT;
          d.phase = 1'b0;                                     // every hand-over opens with a high half-cycle
          d.mode  = MODE_RUN;
        end
      end
      S_RUN: begin
        if (q.cmp < burstThr) begin
          d.st   = S_IM_ON;                                   // intermediate first
          d.cmd  = CMD_BURST_MODE;
          d.stb  = 1'b1;
          d.tmr  = '0;
          d.mode = MODE_IM;
        end
      end
      S_IM_ON: begin
        if (q.cmp > burstThr + BURST_HYST) begin
          d.st   = S_RUN;                                     // load back above entry
          d.cmd  = CMD_RUN;
          d.stb  = 1'b1;
          d.mode = MODE_RUN;
        end else if (q.cmp < (burstThr >> 1)) begin
          d.st   = S_LL_OFF;                                  // lighter load steps down
          d.cmd  = CMD_BURST_STOP;
          d.stb  = 1'b1;
          d.mode = MODE_LL;
        end else if (q.tmr >= TMR_W'(IM_PERIOD - 1)) begin
          d.st  = S_IM_OFF;                                   // forced off every period
          d.cmd = CMD_BURST_STOP;
          d.stb = 1'b1;
          d.tmr = '0;
        end
      end
      S_IM_OFF: begin
        if (winLow) begin
          d.st    = S_IM_ON;                                  // timer keeps running
          d.above = 1'b1;
        end
      end
      S_LL_OFF: begin
        if (winLow && q.env >= 16'(ENV_MIN - 1)) begin
          d.st    = S_LL_ON;
          d.hc    = '0;
          d.env   = '0;
          d.above = 1'b1;
        end
      end
      S_LL_ON: begin
        if (winHigh) begin
          d.st   = (q.hc <= 8'(SL_STEP_HC)) ? S_SL_OFF : S_LL_OFF;
          d.mode = (q.hc <= 8'(SL_STEP_HC)) ? MODE_SL : MODE_LL;
          d.cmd  = CMD_BURST_STOP;
          d.stb  = 1'b1;
          d.tmr  = '0;
        end else if (q.hc >= 8'(LL_EXIT_HC)) begin
          d.st   = S_IM_ON;                                   // heavier load steps up
          d.mode = MODE_IM;
          d.tmr  = '0;
          d.cmp  = FIXED_BURST_LVL;
        end
      end
      S_SL_OFF: begin
        if (winLow) begin
          d.st    = S_LL_ON;
          d.mode  = MODE_LL;
          d.hc    = '0;
          d.env   = '0;
          d.above = 1'b1;
        end else if (q.tmr >= TMR_W'(SL_OFF - 1)) begin
          d.st    = S_SL_ON;                                  // off-time expiry only
          d.sw    = '0;
          d.env   = '0;
          d.above = 1'b1;
        end
      end
      S_SL_ON: begin
        d.sw = q.sw + 1'b1;
        if (winHigh || q.sw >= 11'(SL_SW_CYC - 1)) begin
          d.st  = S_SL_OFF;
          d.cmd = CMD_BURST_STOP;
          d.stb = 1'b1;
          d.tmr = '0;
        end
      end
      S_FAULT: begin
        if (!link.primaryOn && fltS == 2'b00) begin
          d.st = S_WAIT;                                      // primary runs its restart
        end
      end
      default: d.st = S_WAIT;
    endcase
    // half-cycle edges become switching commands
    if (hcEnd && !d.stb && d.st == q.st) begin
      d.phase = ~q.phase;
      d.cmd   = q.phase ? CMD_HB_LO : CMD_HB_HI;
      d.stb   = 1'b1;
      d.hc    = (q.hc == 8'hff) ? q.hc : q.hc + 1'b1;
    end
    // faults and undervoltage hand control back
    if (q.st != S_FAULT && fltS != 2'b00) begin
      d.st    = S_FAULT;
      d.cmd   = CMD_FAULT;
      d.stb   = 1'b1;
      d.inCtl = 1'b0;
      d.mode  = MODE_RUN;
    end else if (q.inCtl && !link.primaryOn) begin
      d.st    = S_FAULT;                                      // primary-side fault seen
      d.cmd   = CMD_NONE;
      d.stb   = 1'b0;
      d.inCtl = 1'b0;
      d.mode  = MODE_RUN;
    end
  end
  // registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '{st: S_WAIT, cmp: CMP_INIT, phase: 1'b0, above: 1'b0, tmr: '0, env: '0, hc: '0,
             sw: '0, cmd: CMD_NONE, stb: 1'b0, strap: 3'h0, strapDone: 1'b0, inCtl: 1'b0,
             mode: MODE_RUN};
    end else begin
      q <= d;
    end
  end
  assign link.isolatedLinkCmd = q.cmd;
  assign link.isolatedLinkStb = q.stb;
  assign inControl            = q.inCtl;
  assign burstMode            = q.mode;
  assign compensationNode     = q.cmp;
endmodule // sbc_secondary
`default_nettype wire

/* File: hw/sbc_pkg.sv */
// Purpose: shared constants and types for the secondary burst control sequencer and its primary partner
// Assumes: 12-bit feedback and winding current codes, 8-bit line code, full scale 5 V on feedback, 4095 = full load on the compensation node
// Notes:   both ends run on sys_clk; the link between them is same-clock logic
//
// Contract
// - primary switches first, then secondary takes over
// - secondary sends handover, switching, burst, fault commands
// - undervoltage or fault returns control to primary
// - primary then latches off or auto-restarts
// - after restart off time, primary repeats start-up
// - every secondary fault is reported to primary; one raised while the secondary is already in S_FAULT is never sent
// - feedback error versus reference, gain raised beyond threshold
// - half-cycle ends when current crosses compensation level
// - half-cycle timing, not frequency, is controlled
// - strap selects burst entry threshold, 15 to 2
// - burst entry threshold compensated for input voltage
// - enter burst before ten percent load
// - three burst modes, intermediate entered first
// - intermediate burst forces off time every 1.5 ms
// - closed loop resumes until off-to-off timer expires
// - light-load burst uses fixed ten percent level
// - light-load burst switches between low and high window
// - super-light burst starts only after 50 ms off
// - low window in super-light returns to light-load
// - super-light burst ends at high window or 60 us
// - output window fixed at plus/minus 0.65 percent
// - burst envelope kept below about 1 kHz; ENV_MIN is enforced in S_LL_OFF only, not from S_SL_OFF
package sbc_pkg;
  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_MHZ        = 25;                          // sys_clk rate
  localparam int IM_PERIOD_US   = 1500;                        // forced off-to-off period
  localparam int IM_PERIOD_CYC  = IM_PERIOD_US * CLK_MHZ;
  localparam int SL_OFF_MS      = 50;                          // super-light maximum off time
  localparam int SL_OFF_CYC     = SL_OFF_MS * 1000 * CLK_MHZ;
  localparam int SL_SW_US       = 60;                          // super-light switching budget
  localparam int SL_SW_CYC      = SL_SW_US * CLK_MHZ;
  localparam int ENV_MIN_US     = 1000;                        // 1 kHz envelope ceiling
  localparam int ENV_MIN_CYC    = ENV_MIN_US * CLK_MHZ;
  localparam int RESTART_MS     = 500;                         // auto-restart off time
  localparam int RESTART_CYC    = RESTART_MS * 1000 * CLK_MHZ;
  localparam int START_HALF_NS  = 5000;                        // start-up half period (100 kHz)
  localparam int START_HALF_CYC = START_HALF_NS * CLK_MHZ / 1000;
  localparam int TMR_W          = 24;                          // timer width
  // ***************************************************************
  // analog codes
  // ***************************************************************
  localparam logic [11:0] OUT_REG_CODE   = 12'hc00;            // 3.75 V reference
  localparam logic [11:0] OUT_WIN_CODE   = 12'h014;            // 0.65 % of reference
  localparam logic [11:0] WIN_LOW_CODE   = OUT_REG_CODE - OUT_WIN_CODE;
  localparam logic [11:0] WIN_HIGH_CODE  = OUT_REG_CODE + OUT_WIN_CODE;
  localparam logic [12:0] NLA_THR        = 13'h0040;           // error where gain boost starts
  localparam int          NLA_SHIFT      = 2;                  // 4x boost
  localparam int          INT_SHIFT      = 4;                  // integrator step scale
  localparam logic [11:0] CMP_INIT       = 12'h800;            // compensation at hand-over
  localparam logic [11:0] FIXED_BURST_LVL = 12'h19a;           // ten percent load
  localparam logic [11:0] BURST_HYST     = 12'h040;            // exit hysteresis
  localparam int          LINE_SHIFT     = 3;                  // input-voltage compensation scale
  localparam logic [11:0] STRAP_LVL [0:7] = '{12'h266, 12'h1eb, 12'h171, 12'h0f6,
                                             12'h0a4, 12'h052, 12'h052, 12'h052};
  // ***************************************************************
  // link commands and modes
  // ***************************************************************
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0, CMD_HANDOVER = 3'h1, CMD_HB_HI = 3'h2, CMD_HB_LO = 3'h3,
    CMD_BURST_MODE = 3'h4, CMD_BURST_STOP = 3'h5, CMD_RUN = 3'h6, CMD_FAULT = 3'h7
  } sbc_cmd_t;
  localparam logic [1:0] MODE_RUN = 2'h0;
  localparam logic [1:0] MODE_IM  = 2'h1;
  localparam logic [1:0] MODE_LL  = 2'h2;
  localparam logic [1:0] MODE_SL  = 2'h3;
endpackage

/* File: hw/sbc_link_if.sv */
// Purpose: isolated link between secondary and primary ends
// Assumes: both ends share sys_clk
// Notes:   one command per strobe; primaryOn is a level
`timescale 1ns/1ns
`default_nettype none
interface sbc_link_if
  import sbc_pkg::*;
(
  input wire logic sys_clk
);
  sbc_cmd_t isolatedLinkCmd;   // command code
  logic     isolatedLinkStb;   // one-cycle command strobe
  logic     primaryOn;         // primary powered and not in off period
  modport sec (input sys_clk, output isolatedLinkCmd, output isolatedLinkStb, input primaryOn);
  modport pri (input sys_clk, input isolatedLinkCmd, input isolatedLinkStb, output primaryOn);
endinterface
`default_nettype wire

/* File: hw/sbc_sync.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: slow-changing pins or codes
// Notes:   first stage feeds only the second
`timescale 1ns/1ns
`default_nettype none
module sbc_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  typedef struct packed {
    logic [W-1:0] meta;   // first stage
    logic [W-1:0] stable; // second stage
  } sbc_sync_t;
  sbc_sync_t q, d;
  // next value
  always_comb begin
    d.meta   = asyncIn;
    d.stable = q.meta;
  end
  // registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign syncOut = q.stable;
endmodule // sbc_sync
`default_nettype wire

/* File: hw/sbc_primary.sv */
// Purpose: primary-side end: start-up switching, follows link commands, owns fault response
// Assumes: fault and undervoltage pins are asynchronous
// Notes:   latchSelect picks latch-off or auto-restart
`timescale 1ns/1ns
`default_nettype none
module sbc_primary
  import sbc_pkg::*;
#(
  parameter int RESTART_OFF = RESTART_CYC,
  parameter int START_HALF  = START_HALF_CYC
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  sbc_link_if.pri   link,
  input  wire logic priFault,
  input  wire logic priUnderVolt,
  input  wire logic latchSelect,
  output logic      hbHighGate,
  output logic      hbLowGate,
  output logic      burstIndicator,
  output logic      latchedOff
);
  if (RESTART_OFF < 1 || RESTART_OFF >= 2**TMR_W || START_HALF < 1 || START_HALF >= 2**TMR_W) begin : g_chk
    $error("sbc_primary: timer parameter out of range");
  end
  // ***************************************************************
  // state
  // ***************************************************************
  typedef enum logic [3:0] {
    P_START = 4'h1, P_SEC = 4'h2, P_RESTART = 4'h4, P_LATCH = 4'h8
  } sbc_pst_t;
  typedef struct packed {
    sbc_pst_t         st;
    logic [TMR_W-1:0] tmr;
    logic             hbHi;
    logic             hbLo;
    logic             burst;
    logic             on;
    logic             latched;
  } sbc_pri_t;
  sbc_pri_t q, d;
  logic [2:0] pinS;   // fault, undervoltage, latch strap
  sbc_sync #(.W(3)) u_pins (
    .sys_clk (sys_clk),
    .rst     (rst),
    .asyncIn ({priFault, priUnderVolt, latchSelect}),
    .syncOut (pinS)
  );
  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    d = q;
    d.tmr = q.tmr + 1'b1;
    case (q.st)
      P_START: begin
        if (q.tmr >= TMR_W'(START_HALF - 1)) begin
          d.hbHi = ~q.hbHi;                          // free-running start-up drive
          d.hbLo = q.hbHi;
          d.tmr  = '0;
        end
        if (link.isolatedLinkStb && link.isolatedLinkCmd == CMD_HANDOVER) begin
          d.st   = P_SEC;                            // secondary now originates switching
          d.hbHi = 1'b0;
          d.hbLo = 1'b0;
        end
      end
      P_SEC: begin
        if (link.isolatedLinkStb) begin
          case (link.isolatedLinkCmd)
            CMD_HB_HI:      begin d.hbHi = 1'b1; d.hbLo = 1'b0; end
            CMD_HB_LO:      begin d.hbHi = 1'b0; d.hbLo = 1'b1; end
            CMD_BURST_STOP: begin d.hbHi = 1'b0; d.hbLo = 1'b0; end
            CMD_BURST_MODE: d.burst = 1'b1;
            CMD_RUN:        d.burst = 1'b0;
            default:        d.burst = q.burst;
          endcase
        end
      end
      P_RESTART: begin
        if (q.tmr >= TMR_W'(RESTART_OFF - 1) && !pinS[2] && !pinS[1]) begin
          d.st  = P_START;                           // same sequence as power-up
          d.on  = 1'b1;
          d.tmr = '0;
        end
      end
      P_LATCH: d.tmr = '0;                           // held until reset
      default: d.st = P_LATCH;
    endcase
    // fault response belongs to this end alone
    if ((q.st == P_START || q.st == P_SEC) &&
        (pinS[2] || pinS[1] || (link.isolatedLinkStb && link.isolatedLinkCmd == CMD_FAULT))) begin
      d.hbHi    = 1'b0;
      d.hbLo    = 1'b0;
      d.burst   = 1'b0;
      d.on      = 1'b0;
      d.tmr     = '0;
      d.st      = pinS[0] ? P_LATCH : P_RESTART;
      d.latched = pinS[0];
    end
  end
  // registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '{st: P_START, tmr: '0, hbHi: 1'b0, hbLo: 1'b0, burst: 1'b0, on: 1'b1, latched: 1'b0};
    end else begin
      q <= d;
    end
  end
  assign hbHighGate     = q.hbHi;
  assign hbLowGate      = q.hbLo;
  assign burstIndicator = q.burst;
  assign latchedOff     = q.latched;
  assign link.primaryOn = q.on;
endmodule // sbc_primary
`default_nettype wire

/* File: test/sbc_link_monitor.sv */
// Purpose: link checker between the secondary and primary ends
// Assumes: same-clock link, sync active-high reset
// Notes:   sees only the link signals
`timescale 1ns/1ns
`default_nettype none
module sbc_link_monitor
  import sbc_pkg::*;
#(
  parameter int RESTART_OFF = 100
) (
  input wire logic     sys_clk,
  input wire logic     rst,
  input wire sbc_cmd_t isolatedLinkCmd,
  input wire logic     isolatedLinkStb,
  input wire logic     primaryOn
);
  // ********
  // helper state
  // ********
  logic own_q;      // secondary holds control
  logic burst_q;    // burst entered, not left
  logic lastHi_q;   // last half-bridge command was high
  int   offCnt_q;   // cycles the primary has been off
  wire logic hand = isolatedLinkStb && isolatedLinkCmd == CMD_HANDOVER;
  // primary going off drops ownership, so a restart begins a fresh order
  always_ff @(posedge sys_clk) begin
    offCnt_q <= primaryOn ? 0 : offCnt_q + 1;
    if (rst || !primaryOn) begin
      {own_q, burst_q, lastHi_q} <= 3'h0;
    end else if (isolatedLinkStb) begin
      case (isolatedLinkCmd)
        CMD_HANDOVER:   own_q <= 1'b1;
        CMD_FAULT:      {own_q, burst_q} <= 2'h0;
        CMD_BURST_MODE: burst_q <= 1'b1;
        CMD_RUN:        burst_q <= 1'b0;
        CMD_HB_HI:      lastHi_q <= 1'b1;
        CMD_HB_LO:      lastHi_q <= 1'b0;
        default:        ;
      endcase
    end
  end
  // ********
  // properties
  // ********
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence faultSent;
    isolatedLinkStb && isolatedLinkCmd == CMD_FAULT && primaryOn;
  endsequence
  sequence primaryOff;
    !primaryOn [*2];
  endsequence
  chk_handover_on: assert property (hand |-> primaryOn)
    else $error("handover while primary off");
  chk_early_cmd: assert property (isolatedLinkStb && primaryOn && !own_q |->
    isolatedLinkCmd inside {CMD_HANDOVER, CMD_FAULT}) else $error("command before handover");
  chk_single_handover: assert property (hand |-> !own_q)
    else $error("second handover");
  chk_fault_stops: assert property (faultSent |=> primaryOff)
    else $error("primary still on after fault");
  chk_hb_high_alt: assert property (isolatedLinkStb && isolatedLinkCmd == CMD_HB_HI |-> !lastHi_q)
    else $error("two high half-cycles");
  chk_hb_low_alt: assert property (isolatedLinkStb && isolatedLinkCmd == CMD_HB_LO |-> lastHi_q)
    else $error("two low half-cycles");
  chk_stop_in_burst: assert property (isolatedLinkStb && isolatedLinkCmd == CMD_BURST_STOP |-> burst_q)
    else $error("off period outside burst");
  chk_run_leaves_burst: assert property (isolatedLinkStb && isolatedLinkCmd == CMD_RUN |-> burst_q)
    else $error("run without burst");
  chk_restart_off: assert property ($rose(primaryOn) |-> offCnt_q >= RESTART_OFF - 2)
    else $error("restart off time short");
endmodule // sbc_link_monitor
`default_nettype wire

/* File: test/tb_top.sv */
// Purpose: both ends joined; hand-over, burst, fault and latch
// Assumes: shortened timers
// Notes:   link commands noted in a queue, a watcher compares
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import sbc_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] fb = 12'hc00, wcs = 12'h000, cmp;
  logic [7:0]  line = 8'h00;
  logic [2:0]  strap = 3'h0;
  logic        secFault = 0, secUv = 0, priFault = 0, priUv = 0, latchSel = 0;
  logic        inControl, hbH, hbL, burstInd, latchedOff;
  logic [1:0]  burstMode;
  int          err_count = 0, compares = 0, cyc = 0;
  sbc_cmd_t    expQ[$];   // expected control commands, oldest first
  always #20 sys_clk = ~sys_clk;
  sbc_link_if link (.sys_clk(sys_clk));
  sbc_secondary #(.IM_PERIOD(200), .SL_OFF(400), .ENV_MIN(50)) sbc_secondary_i (.sys_clk(sys_clk), .rst(rst),
    .link(link), .outputFeedbackSense(fb), .windingCurrentSense(wcs), .lineSense(line),
    .secondaryStrapSelect(strap), .secFault(secFault), .secUnderVolt(secUv), .inControl(inControl),
    .burstMode(burstMode), .compensationNode(cmp));
  sbc_primary #(.RESTART_OFF(100), .START_HALF(5)) sbc_primary_i (.sys_clk(sys_clk), .rst(rst), .link(link),
    .priFault(priFault), .priUnderVolt(priUv), .latchSelect(latchSel), .hbHighGate(hbH), .hbLowGate(hbL),
    .burstIndicator(burstInd), .latchedOff(latchedOff));
  sbc_link_monitor sbc_link_monitor_i (.sys_clk(sys_clk), .rst(rst),
    .isolatedLinkCmd(link.isolatedLinkCmd), .isolatedLinkStb(link.isolatedLinkStb), .primaryOn(link.primaryOn));
  task automatic check(input string nm, input logic [11:0] want, input logic [11:0] got);
    compares++;
    if (got !== want) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, want, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // random winding current makes half-cycle crossings
  always @(negedge sys_clk) wcs <= 12'($urandom % 4096);
  // watcher and hang limit
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
    if (!rst && link.isolatedLinkStb &&
        link.isolatedLinkCmd inside {CMD_HANDOVER, CMD_FAULT, CMD_BURST_MODE, CMD_RUN}) begin
      check("link command", (expQ.size() > 0) ? 12'(expQ.pop_front()) : 12'hfff,
            12'(link.isolatedLinkCmd));
    end
  end
  initial begin
    void'($urandom(32'h7a22));
    strap = 3'($urandom % 5);
    line = 8'($urandom);
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    // output just inside the window: hand-over, then slow fall into burst
    expQ.push_back(CMD_HANDOVER);
    expQ.push_back(CMD_BURST_MODE);
    fb = 12'hc10 + 12'($urandom % 4);
    for (int i = 0; i < 100 && inControl !== 1'b1; i++) @(negedge sys_clk);
    check("inControl", 12'h1, 12'(inControl));
    check("compensationNode", CMP_INIT, cmp);
    for (int i = 0; i < 4000 && burstMode === MODE_RUN; i++) @(negedge sys_clk);
    check("burstMode", 12'(MODE_IM), 12'(burstMode));
    repeat (500) @(negedge sys_clk);
    check("burstIndicator", 12'h1, 12'(burstInd));
    // output low: off ends, load rises, burst left
    expQ.push_back(CMD_RUN);
    fb = 12'hbe0;
    for (int i = 0; i < 2000 && burstMode !== MODE_RUN; i++) @(negedge sys_clk);
    check("burstMode", 12'(MODE_RUN), 12'(burstMode));
    @(negedge sys_clk);
    check("burstIndicator", 12'h0, 12'(burstInd));
    // local fault, then local undervoltage: each reported, primary restarts
    for (int k = 0; k < 2; k++) begin
      expQ.push_back(CMD_FAULT);
      secFault = (k == 0);
      secUv = (k == 1);
      for (int i = 0; i < 50 && link.primaryOn === 1'b1; i++) @(negedge sys_clk);
      check("inControl", 12'h0, 12'(inControl));
      check("primaryOn", 12'h0, 12'(link.primaryOn));
      check("gates", 12'h0, 12'({hbH, hbL}));
      {secFault, secUv} = 2'h0;
      fb = 12'hbf4;
      expQ.push_back(CMD_HANDOVER);
      for (int i = 0; i < 400 && inControl !== 1'b1; i++) @(negedge sys_clk);
      check("inControl", 12'h1, 12'(inControl));
    end
    // primary undervoltage: control falls back with no fault command
    priUv = 1'b1;
    for (int i = 0; i < 50 && inControl === 1'b1; i++) @(negedge sys_clk);
    check("inControl", 12'h0, 12'(inControl));
    priUv = 1'b0;
    expQ.push_back(CMD_HANDOVER);
    for (int i = 0; i < 400 && inControl !== 1'b1; i++) @(negedge sys_clk);
    check("inControl", 12'h1, 12'(inControl));
    // primary fault with latch-off chosen
    latchSel = 1'b1;
    priFault = 1'b1;
    for (int i = 0; i < 50 && inControl === 1'b1; i++) @(negedge sys_clk);
    check("inControl", 12'h0, 12'(inControl));
    repeat (200) @(negedge sys_clk);
    check("latchedOff", 12'h1, 12'(latchedOff));
    check("gates", 12'h0, 12'({hbH, hbL}));
    check("primaryOn", 12'h0, 12'(link.primaryOn));
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
